/* File: design/brk_pkg.sv */
package brk_pkg;

	// Register addresses on the 16-bit register port.
	localparam logic [15:0] ADDR_FLAG_CLR_CTRL = 16'hFE03;
	localparam logic [15:0] ADDR_EXIT_STATUS   = 16'hFE00;
	localparam logic [15:0] ADDR_BKPT_HIGH     = 16'hFE0C;
	localparam logic [15:0] ADDR_BKPT_LOW      = 16'hFE0D;
	localparam logic [15:0] ADDR_CTRL_STATUS   = 16'hFE0E;
	localparam logic [15:0] ADDR_IRQ_STATUS    = 16'hFE10;
	localparam logic [15:0] ADDR_IRQ_MASK      = 16'hFE11;

	// Field positions.
	localparam int BIT_BREAK_ENABLE = 7;
	localparam int BIT_BREAK_ACTIVE = 6;
	localparam int BIT_CLEAR_ENABLE = 7;
	localparam int BIT_EXIT_FLAG    = 1;
	localparam int EVT_BREAK        = 0;
	localparam int EVT_LOWPWR_EXIT  = 1;
	localparam int EVT_WIDTH        = 2;

	// Vectors and opcodes steered into the core.
	localparam logic [15:0] VEC_NORMAL   = 16'hFFFC;
	localparam logic [15:0] VEC_MONITOR  = 16'hFEFC;
	localparam logic [7:0]  OPC_SOFT_INT = 8'h83;

	localparam logic [7:0]  BYTE_ZERO = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_PENDING = 2'b01,
		ST_BREAK   = 2'b10
	} brk_state_t;

	// Status from the core.
	typedef struct packed {
		logic [15:0] pc;
		logic        pc_valid;
		logic        instr_last;
		logic        rti_exec;
		logic        wait_mode;
		logic        stop_mode;
		logic        monitor_mode;
	} cpu_status_t;

	// Steering back to the core.
	typedef struct packed {
		logic        force_swi;
		logic [7:0]  opcode;
		logic [15:0] vector;
		logic        wake;
	} cpu_steer_t;

endpackage : brk_pkg

/* File: design/address_breakpoint_unit.sv */
// Summary of operation
// - On break start force soft-interrupt opcode and normal or monitor vector.
// - Break starts after current instruction; at once on its last cycle.
// - All timer counters halted while break is active.
// - Watchdog disabled during break only with test high voltage present.
// - Unit works in wait mode; break ends wait and sets exit flag.
// - Break ends stop mode and sets the exit flag.
// - Break enable bit 7: matches trigger breaks only when set; reset clears.
// - Break active bit is set on every address match; reset clears.
// - Writing one to break active while it reads zero starts a break like a match.
// - Two address byte registers form the compare address; reset zeroes them.
// - Exit flag reads one when stop or wait ended by break.
// - Writing zero to the exit flag clears it, but during a break only with clear-enable set.
// - Clear-enable bit gates status clearing during break; resets to zero.
// - Compare address is the core program counter; match signals the core.
// - Return from interrupt in the routine ends break and restarts timers.
// - Low address byte at its own address; control bits 5 to 0 read zero.
module address_breakpoint_unit (
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	// Register port.
	input  wire logic [15:0]          reg_addr_i,
	input  wire logic [7:0]           reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [7:0]           reg_rdata_o,
	// Core side.
	input  wire brk_pkg::cpu_status_t cpu_i,
	input  wire logic                 test_high_voltage_i,
	output brk_pkg::cpu_steer_t       cpu_o,
	output logic                      breakpoint_o,
	output logic                      break_state_o,
	output logic                      timer_halt_o,
	output logic                      watchdog_disable_o,
	output logic                      status_clear_allow_o,
	// Interrupt.
	output logic                      irq_o
);

	logic [7:0]                     bkpt_high_r;
	logic [7:0]                     bkpt_low_r;
	logic                           break_enable_r;
	logic                           break_active_r;
	logic                           clear_enable_r;
	logic                           exit_flag_r;
	logic [brk_pkg::EVT_WIDTH-1:0]  irq_status_r;
	logic [brk_pkg::EVT_WIDTH-1:0]  irq_mask_r;
	brk_pkg::brk_state_t            state_r;
	brk_pkg::brk_state_t            state_nxt;

	logic wr_ctrl;
	logic addr_match;
	logic soft_break;
	logic break_start;
	logic lowpwr;
	logic break_clear_enable_gate;

	function automatic logic wr_hit(input logic [15:0] a);
		wr_hit = reg_wr_i && (reg_addr_i == a);
	endfunction : wr_hit

	assign wr_ctrl = wr_hit(brk_pkg::ADDR_CTRL_STATUS);
	// Match against the fetch address of the core.
	assign addr_match = break_enable_r && cpu_i.pc_valid &&
		(cpu_i.pc == {bkpt_high_r, bkpt_low_r});
	assign soft_break = wr_ctrl && reg_wdata_i[brk_pkg::BIT_BREAK_ACTIVE] &&
		!break_active_r;
	assign lowpwr = cpu_i.wait_mode || cpu_i.stop_mode;
	// Status clearing by software is blocked during a break unless enabled.
	assign break_clear_enable_gate = (state_r != brk_pkg::ST_BREAK) || clear_enable_r;

	// Break start: immediate on last cycle or in low power, else deferred.
	always_comb begin
		state_nxt = state_r;
		break_start = 1'b0;
		case (state_r)
			brk_pkg::ST_IDLE: begin
				if (addr_match || soft_break) begin
					if (cpu_i.instr_last || lowpwr) begin
						state_nxt = brk_pkg::ST_BREAK;
						break_start = 1'b1;
					end else begin
						state_nxt = brk_pkg::ST_PENDING;
					end
				end
			end
			brk_pkg::ST_PENDING: begin
				if (cpu_i.instr_last || lowpwr) begin
					state_nxt = brk_pkg::ST_BREAK;
					break_start = 1'b1;
				end
			end
			brk_pkg::ST_BREAK: begin
				if (cpu_i.rti_exec) begin
					state_nxt = brk_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = brk_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_r <= brk_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Breakpoint address bytes.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			bkpt_high_r <= brk_pkg::BYTE_ZERO;
			bkpt_low_r  <= brk_pkg::BYTE_ZERO;
		end else begin
			if (wr_hit(brk_pkg::ADDR_BKPT_HIGH)) begin
				bkpt_high_r <= reg_wdata_i;
			end
			if (wr_hit(brk_pkg::ADDR_BKPT_LOW)) begin
				bkpt_low_r <= reg_wdata_i;
			end
		end
	end

	// Control and status: only bits 7 and 6 are stored.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			break_enable_r <= 1'b0;
		end else if (wr_ctrl) begin
			break_enable_r <= reg_wdata_i[brk_pkg::BIT_BREAK_ENABLE];
		end
	end

	// Match sets win over a clearing write in the same cycle.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			break_active_r <= 1'b0;
		end else if (addr_match) begin
			break_active_r <= 1'b1;
		end else if (wr_ctrl) begin
			break_active_r <= reg_wdata_i[brk_pkg::BIT_BREAK_ACTIVE];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			clear_enable_r <= 1'b0;
		end else if (wr_hit(brk_pkg::ADDR_FLAG_CLR_CTRL)) begin
			clear_enable_r <= reg_wdata_i[brk_pkg::BIT_CLEAR_ENABLE];
		end
	end

	// Exit flag: set by a break that leaves wait or stop; cleared by writing zero outside a break or with clear-enable set.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			exit_flag_r <= 1'b0;
		end else if (break_start && lowpwr) begin
			exit_flag_r <= 1'b1;
		end else if (wr_hit(brk_pkg::ADDR_EXIT_STATUS) &&
			!reg_wdata_i[brk_pkg::BIT_EXIT_FLAG] && break_clear_enable_gate) begin
			exit_flag_r <= 1'b0;
		end
	end

	// Sticky event bits, write one to clear; a new event wins over the clear.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_status_r <= '0;
		end else begin
			for (int i = 0; i < brk_pkg::EVT_WIDTH; i++) begin
				if (wr_hit(brk_pkg::ADDR_IRQ_STATUS) && reg_wdata_i[i]) begin
					irq_status_r[i] <= 1'b0;
				end
			end
			if (break_start) begin
				irq_status_r[brk_pkg::EVT_BREAK] <= 1'b1;
			end
			if (break_start && lowpwr) begin
				irq_status_r[brk_pkg::EVT_LOWPWR_EXIT] <= 1'b1;
			end
		end
	end

	// Interrupt mask, same layout as the event bits.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_mask_r <= '0;
		end else if (wr_hit(brk_pkg::ADDR_IRQ_MASK)) begin
			irq_mask_r <= reg_wdata_i[brk_pkg::EVT_WIDTH-1:0];
		end
	end

	// Read data one cycle after the strobe; unmapped and reserved bits read zero.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= brk_pkg::BYTE_ZERO;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				brk_pkg::ADDR_EXIT_STATUS: begin
					reg_rdata_o <= {6'h00, exit_flag_r, 1'b0};
				end
				brk_pkg::ADDR_FLAG_CLR_CTRL: begin
					reg_rdata_o <= {clear_enable_r, 7'h00};
				end
				brk_pkg::ADDR_BKPT_HIGH: begin
					reg_rdata_o <= bkpt_high_r;
				end
				brk_pkg::ADDR_BKPT_LOW: begin
					reg_rdata_o <= bkpt_low_r;
				end
				brk_pkg::ADDR_CTRL_STATUS: begin
					reg_rdata_o <= {break_enable_r, break_active_r, 6'h00};
				end
				brk_pkg::ADDR_IRQ_STATUS: begin
					reg_rdata_o <= {6'h00, irq_status_r};
				end
				brk_pkg::ADDR_IRQ_MASK: begin
					reg_rdata_o <= {6'h00, irq_mask_r};
				end
				default: begin
					reg_rdata_o <= brk_pkg::BYTE_ZERO;
				end
			endcase
		end else begin
			reg_rdata_o <= brk_pkg::BYTE_ZERO;
		end
	end

	// Registered steering outputs to the core.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cpu_o <= '0;
		end else begin
			cpu_o.force_swi <= break_start;
			cpu_o.opcode    <= brk_pkg::OPC_SOFT_INT;
			cpu_o.vector    <= cpu_i.monitor_mode ? brk_pkg::VEC_MONITOR
				: brk_pkg::VEC_NORMAL;
			cpu_o.wake      <= break_start && lowpwr;
		end
	end

	// Match indication back to the core.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			breakpoint_o <= 1'b0;
		end else begin
			breakpoint_o <= addr_match;
		end
	end

	// Break state and timer freeze follow the next state, so they rise with the forced fetch.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			break_state_o <= 1'b0;
			timer_halt_o  <= 1'b0;
		end else begin
			break_state_o <= (state_nxt == brk_pkg::ST_BREAK);
			timer_halt_o  <= (state_nxt == brk_pkg::ST_BREAK);
		end
	end

	// The watchdog is only released while the test voltage is present.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			watchdog_disable_o <= 1'b0;
		end else begin
			watchdog_disable_o <= (state_nxt == brk_pkg::ST_BREAK) &&
				test_high_voltage_i;
		end
	end

	// Status clearing elsewhere in the device is allowed outside a break.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			status_clear_allow_o <= 1'b1;
		end else begin
			status_clear_allow_o <= (state_nxt != brk_pkg::ST_BREAK) ||
				clear_enable_r;
		end
	end

	// Level interrupt from the unmasked sticky bits.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status_r & irq_mask_r);
		end
	end

endmodule : address_breakpoint_unit

/* File: verification/brk_checker_properties.sv */
module brk_checker (
	// Clock and reset.
	input wire logic                 clk_i,
	input wire logic                 rstn_i,
	// Watched ports.
	input wire logic                 reg_rd_i,
	input wire logic [7:0]           reg_rdata_o,
	input wire brk_pkg::cpu_status_t cpu_i,
	input wire brk_pkg::cpu_steer_t  cpu_o,
	input wire logic                 break_state_o,
	input wire logic                 timer_halt_o,
	input wire logic                 watchdog_disable_o,
	input wire logic                 status_clear_allow_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_halt;
		timer_halt_o == break_state_o;
	endproperty
	a_halt: assert property (p_halt) else $error("timer halt differs from break");
	property p_wdog;
		watchdog_disable_o |-> break_state_o;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog off outside break");
	property p_vec;
		cpu_o.force_swi |-> cpu_o.opcode == brk_pkg::OPC_SOFT_INT && cpu_o.vector ==
			($past(cpu_i.monitor_mode) ? brk_pkg::VEC_MONITOR : brk_pkg::VEC_NORMAL);
	endproperty
	a_vec: assert property (p_vec) else $error("wrong opcode or vector");
	property p_pulse;
		cpu_o.force_swi |=> !cpu_o.force_swi;
	endproperty
	a_pulse: assert property (p_pulse) else $error("force pulse too long");
	property p_enter;
		cpu_o.force_swi |-> break_state_o;
	endproperty
	a_enter: assert property (p_enter) else $error("force without break");
	property p_rti;
		break_state_o && cpu_i.rti_exec |=> !break_state_o;
	endproperty
	a_rti: assert property (p_rti) else $error("break not ended");
	property p_wake;
		cpu_o.wake |-> cpu_o.force_swi;
	endproperty
	a_wake: assert property (p_wake) else $error("wake without break start");
	property p_clr;
		!status_clear_allow_o |-> break_state_o;
	endproperty
	a_clr: assert property (p_clr) else $error("clear blocked outside break");
	property p_rd;
		!$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
	endproperty
	a_rd: assert property (p_rd) else $error("read data outside its cycle");
endmodule : brk_checker

bind address_breakpoint_unit brk_checker chk (
	.clk_i(clk_i), .rstn_i(rstn_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.cpu_i(cpu_i), .cpu_o(cpu_o), .break_state_o(break_state_o),
	.timer_halt_o(timer_halt_o), .watchdog_disable_o(watchdog_disable_o),
	.status_clear_allow_o(status_clear_allow_o)
);

/* File: verification/cpu_model.sv */
module cpu_model (
	// Clock and reset.
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	// Controls from the bench.
	input  wire brk_pkg::cpu_steer_t steer_i,
	input  wire logic [15:0]         pc_i,
	input  wire logic                rti_i,
	input  wire logic [1:0]          lp_i,
	input  wire logic                mon_i,
	// Core status.
	output brk_pkg::cpu_status_t     cpu_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       last_r;
	logic [1:0] lp_r;
	// Every instruction takes two cycles.
	always_ff @(posedge clk_i) begin
		last_r <= rstn_i & ~last_r;
	end
	// Low-power mode holds until the unit wakes the core.
	always_ff @(posedge clk_i) begin
		if (!rstn_i || steer_i.wake) begin
			lp_r <= 2'b00;
		end else if (lp_i != 2'b00) begin
			lp_r <= lp_i;
		end
	end
	assign cpu_o = '{pc: pc_i, pc_valid: 1'b1, instr_last: last_r, rti_exec: rti_i,
		wait_mode: lp_r[0], stop_mode: lp_r[1], monitor_mode: mon_i};
endmodule : cpu_model

/* File: verification/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0, rstn_i = 1'b0, wr = 1'b0, rd = 1'b0, tvh = 1'b0, return_from_interrupt_opcode = 1'b0, mon = 1'b0;
	logic [15:0] a = 16'h0000, pc = 16'h0000;
	logic [7:0] wd = 8'h00, rdata;
	logic [1:0] lp = 2'b00;
	logic bp, bs, th, wdg, sca, irq;
	brk_pkg::cpu_status_t cpu;
	brk_pkg::cpu_steer_t steer;
	int failures = 0, compares = 0;
	always #12.5 clk_i = ~clk_i;
	cpu_model core (.clk_i(clk_i), .rstn_i(rstn_i), .steer_i(steer), .pc_i(pc), .rti_i(return_from_interrupt_opcode),
		.lp_i(lp), .mon_i(mon), .cpu_o(cpu));
	address_breakpoint_unit dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(a),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cpu_i(cpu),
		.test_high_voltage_i(tvh), .cpu_o(steer), .breakpoint_o(bp), .break_state_o(bs),
		.timer_halt_o(th), .watchdog_disable_o(wdg), .status_clear_allow_o(sca), .irq_o(irq));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wt
	task automatic wrr(input logic [15:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		a <= ad;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wrr
	task automatic rdc(input logic [15:0] ad, input logic [7:0] exp);
		@(posedge clk_i);
		a <= ad;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rdc
	task automatic ret;
		pc <= 16'h0000;
		wrr(brk_pkg::ADDR_CTRL_STATUS, 8'h80);
		return_from_interrupt_opcode <= 1'b1;
		@(posedge clk_i);
		return_from_interrupt_opcode <= 1'b0;
		wt(2);
		chk(bs, 1'b0);
	endtask : ret
	task automatic results;
		if (failures == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	initial begin
		repeat (3000) @(posedge clk_i);
		failures++;
		results();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		rdc(brk_pkg::ADDR_BKPT_HIGH, 8'h00);
		rdc(brk_pkg::ADDR_CTRL_STATUS, 8'h00);
		rdc(brk_pkg::ADDR_EXIT_STATUS, 8'h00);
		rdc(brk_pkg::ADDR_FLAG_CLR_CTRL, 8'h00);
		rdc(16'hFE01, 8'h00);
		wrr(brk_pkg::ADDR_BKPT_HIGH, 8'h12);
		wrr(brk_pkg::ADDR_BKPT_LOW, 8'h34);
		wrr(brk_pkg::ADDR_FLAG_CLR_CTRL, 8'h7F);
		wrr(brk_pkg::ADDR_CTRL_STATUS, 8'h3F);
		rdc(brk_pkg::ADDR_BKPT_HIGH, 8'h12);
		rdc(brk_pkg::ADDR_BKPT_LOW, 8'h34);
		rdc(brk_pkg::ADDR_FLAG_CLR_CTRL, 8'h00);
		pc <= 16'h1234;
		rdc(brk_pkg::ADDR_CTRL_STATUS, 8'h00);
		chk(bs, 1'b0);
		wrr(brk_pkg::ADDR_CTRL_STATUS, 8'h80);
		wt(4);
		chk({bp, bs, th, wdg}, 4'b1110);
		rdc(brk_pkg::ADDR_CTRL_STATUS, 8'hC0);
		tvh <= 1'b1;
		wt(3);
		chk(wdg, 1'b1);
		ret();
		mon <= 1'b1;
		wrr(brk_pkg::ADDR_CTRL_STATUS, 8'hC0);
		wt(4);
		chk(bs, 1'b1);
		ret();
		for (int m = 1; m < 3; m++) begin
			lp <= m[1:0];
			@(posedge clk_i);
			lp <= 2'b00;
			pc <= 16'h1234;
			wt(4);
			rdc(brk_pkg::ADDR_EXIT_STATUS, 8'h02);
			wrr(brk_pkg::ADDR_EXIT_STATUS, 8'h00);
			rdc(brk_pkg::ADDR_EXIT_STATUS, 8'h02);
			wrr(brk_pkg::ADDR_FLAG_CLR_CTRL, 8'h80);
			wrr(brk_pkg::ADDR_EXIT_STATUS, 8'h00);
			rdc(brk_pkg::ADDR_EXIT_STATUS, 8'h00);
			wrr(brk_pkg::ADDR_FLAG_CLR_CTRL, 8'h00);
			ret();
		end
		rdc(brk_pkg::ADDR_IRQ_STATUS, 8'h03);
		chk(irq, 1'b0);
		wrr(brk_pkg::ADDR_IRQ_MASK, 8'h03);
		wt(2);
		chk(irq, 1'b1);
		wrr(brk_pkg::ADDR_IRQ_STATUS, 8'h03);
		wt(2);
		chk(irq, 1'b0);
		results();
	end
endmodule : testbench
